// *** hw/slr_drive.sv ***
// drive end: stroke limit stop, overrun alarm, return gating, release assessment
// assumes synchronous inputs, one clock; the axis position takes position commands and integrates velocity commands
`timescale 1ns/1ps
`include "slr_params.svh"
module slr_drive #(
    parameter int POS_W = `SLR_POS_W
) (
    input  wire logic            core_clk_i,
    input  wire logic            rst_b_i,
    slr_link_if.drive            link,
    input  wire logic [2:0]      in_pin_i,            // three configurable input pins, active high = on
    input  wire slr_pkg::slr_fn_t input_pin_a_function_i,
    input  wire slr_pkg::slr_fn_t input_pin_b_function_i,
    input  wire slr_pkg::slr_fn_t input_pin_c_function_i,
    input  wire logic            stroke_warning_select_i,
    input  wire logic            auto_on_select_i,
    input  wire logic            limit_enable_scope_i,
    input  wire logic            sensor_source_select_i,
    input  wire logic            pole_detect_limit_enable_i,
    input  wire logic            pole_detect_active_i,
    input  wire logic            release_assess_select_i,
    input  wire logic            travel_direction_select_i,
    input  wire logic            home_done_i,          // homing finished pulse
    output logic                 motor_stop_o,
    output logic                 dog_o
);
    import slr_pkg::*;

    // the state struct uses the package position type, so a different width cannot be served
    if (POS_W != `SLR_POS_W) begin : g_pos_w_check
        $error("slr_drive: POS_W must match package position width");
    end

    typedef struct packed {
        slr_pos_t pos;
        slr_pos_t latch;
        logic     up_off_q;     // previous upper limit off state
        logic     lo_off_q;
        logic     hold_up;      // upper direction blocked until release
        logic     hold_lo;
        logic     warn;
        logic     alarm;
        logic     home;
        logic     stop;
        logic     dog;
        logic     up_rep;
        logic     lo_rep;
        logic     held;         // registered copy of either hold, drives status bit 12
    } slr_drv_st_t;

    slr_drv_st_t r;
    slr_drv_st_t next_r;

    // pick the pin whose function code matches
    function automatic logic pin_pick(input slr_fn_t code, input logic [2:0] pins,
                                      input slr_fn_t fa, input slr_fn_t fb, input slr_fn_t fc);
        pin_pick = (fa == code && pins[0]) || (fb == code && pins[1]) || (fc == code && pins[2]);
    endfunction

    // signed distance of a past b, positive when a lies above b
    function automatic logic signed [POS_W:0] past(input slr_pos_t a, input slr_pos_t b);
        past = $signed({a[POS_W-1], a}) - $signed({b[POS_W-1], b});
    endfunction

    logic fwd_travel_end_in;
    logic rev_travel_end_in;
    logic up_on;
    logic lo_on;
    logic lim_en;
    logic up_off;
    logic lo_off;
    logic cyc;
    logic pos_mode;
    logic signed [POS_W:0] d_cmd;
    logic signed [POS_W:0] ovr;
    logic signed [POS_W:0] d_pos;
    logic toward_up;
    logic toward_lo;

    always_comb begin
        // pin decode, auto-on wins over the pins
        fwd_travel_end_in = pin_pick(`SLR_FN_FWD_END, in_pin_i, input_pin_a_function_i,
                                     input_pin_b_function_i, input_pin_c_function_i)
                            || (auto_on_select_i == `SLR_SEL_ON);
        rev_travel_end_in = pin_pick(`SLR_FN_REV_END, in_pin_i, input_pin_a_function_i,
                                     input_pin_b_function_i, input_pin_c_function_i)
                            || (auto_on_select_i == `SLR_SEL_ON);
        // own pins mapped by travel direction, or controller inputs directly
        if (sensor_source_select_i == `SLR_SEL_OFF) begin
            up_on = (travel_direction_select_i == `SLR_SEL_OFF) ? fwd_travel_end_in : rev_travel_end_in;
            lo_on = (travel_direction_select_i == `SLR_SEL_OFF) ? rev_travel_end_in : fwd_travel_end_in;
        end else begin
            up_on = link.ctrl_upper_travel_limit;
            lo_on = link.ctrl_lower_travel_limit;
        end
        lim_en = ((limit_enable_scope_i == `SLR_SEL_OFF) || (link.mode == `SLR_MODE_HM))
                 && !(pole_detect_active_i && pole_detect_limit_enable_i == `SLR_SEL_ON);
        up_off = lim_en && !up_on;
        lo_off = lim_en && !lo_on;
        cyc = (link.mode == `SLR_MODE_CSP) || (link.mode == `SLR_MODE_CSV);
        pos_mode = (link.mode == `SLR_MODE_CSP) || (link.mode == `SLR_MODE_PP);
        // direction of the command: position modes compare to current position, velocity by sign
        d_cmd = pos_mode ? past(link.cmd_target, r.pos) : $signed({link.cmd_target[POS_W-1], link.cmd_target});
        toward_up = d_cmd > 0;
        toward_lo = d_cmd < 0;
        ovr = toward_up ? past(link.cmd_target, r.latch) : past(r.latch, link.cmd_target);
        d_pos = past(r.pos, r.latch);
    end

    // one next-state process for the whole drive end
    always_comb begin
        next_r = r;
        next_r.up_off_q = up_off;
        next_r.lo_off_q = lo_off;
        next_r.up_rep = up_on;
        next_r.lo_rep = lo_on;
        next_r.dog = pin_pick(`SLR_FN_DOG, in_pin_i, input_pin_a_function_i,
                              input_pin_b_function_i, input_pin_c_function_i);
        // latch the axis position on the off edge
        if ((up_off && !r.up_off_q) || (lo_off && !r.lo_off_q)) begin
            next_r.latch = r.pos;
        end
        if (up_off) next_r.hold_up = 1'b1;
        if (lo_off) next_r.hold_lo = 1'b1;
        // release: plain on switch return, or after position reaches latch in csp/csv
        if (!up_off && r.hold_up) begin
            if (release_assess_select_i == `SLR_SEL_OFF || !cyc) begin
                next_r.hold_up = 1'b0;
            end else if (d_pos <= 0) begin
                next_r.hold_up = 1'b0;
            end
        end
        if (!lo_off && r.hold_lo) begin
            if (release_assess_select_i == `SLR_SEL_OFF || !cyc) begin
                next_r.hold_lo = 1'b0;
            end else if (d_pos >= 0) begin
                next_r.hold_lo = 1'b0;
            end
        end
        next_r.held = next_r.hold_up || next_r.hold_lo;
        next_r.warn = (next_r.hold_up || next_r.hold_lo)
                      && (stroke_warning_select_i == `SLR_SEL_OFF);
        next_r.stop = up_off || lo_off;
        // accept commands not heading into a held direction
        if (link.cmd_valid) begin
            if (!((toward_up && r.hold_up) || (toward_lo && r.hold_lo))) begin
                next_r.pos = pos_mode ? link.cmd_target : slr_pos_t'(r.pos + link.cmd_target);
            end else if (link.mode == `SLR_MODE_CSP
                         && ovr >= $signed({1'b0, slr_pos_t'(1) << `SLR_OVERRUN_BITS})) begin
                next_r.alarm = 1'b1;
                next_r.home = 1'b0;
            end
        end
        if (home_done_i && !next_r.alarm) next_r.home = 1'b1;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.actual_pos          = r.pos;
    assign link.status_bit12        = r.held;
    assign link.upper_travel_limit  = r.up_rep;
    assign link.lower_travel_limit  = r.lo_rep;
    assign link.command_error_alarm = r.alarm;
    assign link.stroke_warning      = r.warn;
    assign link.home_valid          = r.home;
    assign motor_stop_o             = r.stop;
    assign dog_o                    = r.dog;
endmodule // slr_drive

// *** hw/slr_params.svh ***
// shared constants for the stroke limit stop and release block
// assumes inclusion by both ends and the verification side
`ifndef SLR_PARAMS_SVH
`define SLR_PARAMS_SVH
`define SLR_POS_W          32
`define SLR_OVERRUN_BITS   30
`define SLR_FN_W           8
`define SLR_FN_FWD_END     8'h0A
`define SLR_FN_REV_END     8'h0B
`define SLR_FN_DOG         8'h22
`define SLR_MODE_W         3
`define SLR_MODE_CSP       3'h0
`define SLR_MODE_CSV       3'h1
`define SLR_MODE_PP        3'h2
`define SLR_MODE_PV        3'h3
`define SLR_MODE_HM        3'h4
`define SLR_MODE_OTHER     3'h5
`define SLR_SEL_OFF        1'h0
`define SLR_SEL_ON         1'h1
`define SLR_CLK_NS         4
`define SLR_MIN_ACTIVE_MS  10
`endif

// *** hw/slr_pkg.sv ***
// types shared by both ends of the stroke limit link
// assumes slr_params.svh is on the include path
`include "slr_params.svh"
package slr_pkg;
    typedef logic [`SLR_POS_W-1:0]  slr_pos_t;
    typedef logic [`SLR_MODE_W-1:0] slr_mode_t;
    typedef logic [`SLR_FN_W-1:0]   slr_fn_t;
    typedef enum logic [2:0] {
        SLR_ST_IDLE = 3'b001,
        SLR_ST_HOLD = 3'b010,
        SLR_ST_SEND = 3'b100
    } slr_ctl_st_t;
endpackage

// *** hw/slr_link_if.sv ***
// link between the drive end and the motion controller end
// assumes both ends share core_clk_i
`timescale 1ns/1ps
interface slr_link_if;
    import slr_pkg::*;
    logic      cmd_valid;    // controller command strobe
    slr_pos_t  cmd_target;   // position (csp/pp) or velocity (csv/pv)
    slr_mode_t mode;         // modes of operation
    logic      ctrl_upper_travel_limit;
    logic      ctrl_lower_travel_limit;
    slr_pos_t  actual_pos;   // position actual value
    logic      status_bit12; // set while a limit holds the axis
    logic      upper_travel_limit; // limit reported to controller
    logic      lower_travel_limit;
    logic      command_error_alarm;
    logic      stroke_warning;
    logic      home_valid;
    modport drive (input cmd_valid, cmd_target, mode, ctrl_upper_travel_limit, ctrl_lower_travel_limit,
                   output actual_pos, status_bit12, upper_travel_limit, lower_travel_limit,
                   command_error_alarm, stroke_warning, home_valid);
    modport ctrl  (output cmd_valid, cmd_target, mode, ctrl_upper_travel_limit, ctrl_lower_travel_limit,
                   input actual_pos, status_bit12, upper_travel_limit, lower_travel_limit,
                   command_error_alarm, stroke_warning, home_valid);
endinterface

// *** hw/slr_ctrl.sv ***
// controller end: forwards user commands, runs the limit recovery sequence
// assumes the drive end shares core_clk_i
`timescale 1ns/1ps
`include "slr_params.svh"
module slr_ctrl (
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    slr_link_if.ctrl               link,
    input  wire logic              user_cmd_valid_i,
    input  wire slr_pkg::slr_pos_t user_cmd_target_i,
    input  wire slr_pkg::slr_mode_t user_mode_i,
    input  wire logic              user_upper_sw_i,   // limit switches wired to the controller
    input  wire logic              user_lower_sw_i,
    input  wire logic              user_recover_i,    // request move away from the limit
    input  wire slr_pkg::slr_pos_t user_away_step_i,  // magnitude of the return move
    output logic                   busy_o
);
    import slr_pkg::*;

    typedef struct packed {
        slr_ctl_st_t st;
        logic        vld;
        slr_pos_t    tgt;
        slr_mode_t   mode;
        logic        up;
        logic        lo;
        logic        dir_down;  // recovery heads toward lower positions
        logic        busy;      // registered so busy_o comes straight from a flop
    } slr_ctl_rg_t;

    slr_ctl_rg_t r;
    slr_ctl_rg_t next_r;

    function automatic slr_pos_t away(input slr_pos_t base, input slr_pos_t step, input logic dn);
        away = dn ? slr_pos_t'(base - step) : slr_pos_t'(base + step);
    endfunction

    always_comb begin
        next_r = r;
        next_r.vld = 1'b0;
        next_r.mode = user_mode_i;
        next_r.up = user_upper_sw_i;
        next_r.lo = user_lower_sw_i;
        case (r.st)
            SLR_ST_IDLE: begin
                if (user_recover_i) begin
                    next_r.dir_down = !link.upper_travel_limit;
                    if (user_mode_i == `SLR_MODE_CSP) begin
                        // align target with actual first so no jump is commanded
                        next_r.vld = 1'b1;
                        next_r.tgt = link.actual_pos;
                        next_r.st = SLR_ST_HOLD;
                    end else if (user_mode_i == `SLR_MODE_CSV) begin
                        next_r.st = SLR_ST_HOLD;
                    end else begin
                        next_r.st = SLR_ST_SEND;
                    end
                end else if (user_cmd_valid_i) begin
                    next_r.vld = 1'b1;
                    next_r.tgt = user_cmd_target_i;
                end
            end
            SLR_ST_HOLD: begin
                // wait for the drive to drop its limit status before moving away
                if (!link.status_bit12) next_r.st = SLR_ST_SEND;
            end
            SLR_ST_SEND: begin
                next_r.vld = 1'b1;
                if (r.mode == `SLR_MODE_CSP || r.mode == `SLR_MODE_PP) begin
                    next_r.tgt = away(link.actual_pos, user_away_step_i, r.dir_down);
                end else begin
                    next_r.tgt = away('0, user_away_step_i, r.dir_down);
                end
                next_r.st = SLR_ST_IDLE;
            end
            default: next_r.st = SLR_ST_IDLE;
        endcase
        next_r.busy = (next_r.st != SLR_ST_IDLE);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            r <= '{st: SLR_ST_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // switches are passed through a register; they must stay off at least the qualifying time
    assign link.cmd_valid               = r.vld;
    assign link.cmd_target              = r.tgt;
    assign link.mode                    = r.mode;
    assign link.ctrl_upper_travel_limit = r.up;
    assign link.ctrl_lower_travel_limit = r.lo;
    assign busy_o                       = r.busy;
endmodule // slr_ctrl

// *** tb/slr_monitor.sv ***
// concurrent checks on the stroke limit link between the drive and controller ends
// assumes instantiation beside the link, one clock and an active-low synchronous reset
`timescale 1ns/1ps
`include "slr_params.svh"
module slr_monitor (
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               cmd_valid,
    input  wire slr_pkg::slr_pos_t  cmd_target,
    input  wire slr_pkg::slr_mode_t mode,
    input  wire slr_pkg::slr_pos_t  actual_pos,
    input  wire logic               status_bit12,
    input  wire logic               upper_travel_limit,
    input  wire logic               lower_travel_limit,
    input  wire logic               command_error_alarm,
    input  wire logic               stroke_warning,
    input  wire logic               home_valid
);
    import slr_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // a command is free only when nothing holds the axis, so it must always be taken
    logic free_cmd;
    assign free_cmd = cmd_valid && !status_bit12 && upper_travel_limit && lower_travel_limit;

    a_alarm_sticky: assert property (command_error_alarm |=> command_error_alarm)
        else $error("command alarm dropped without reset");
    a_alarm_cause: assert property ($rose(command_error_alarm) |-> $past(cmd_valid) && $past(mode) == `SLR_MODE_CSP)
        else $error("command alarm without a csp command");
    a_alarm_home: assert property ($rose(command_error_alarm) |-> ##[0:1] !home_valid)
        else $error("home position kept after command alarm");
    a_pp_follow: assert property (free_cmd && mode == `SLR_MODE_PP |=> actual_pos == $past(cmd_target))
        else $error("free position command not taken");
    a_pv_integrate: assert property (free_cmd && mode == `SLR_MODE_PV |=>
        actual_pos == $past(actual_pos) + $past(cmd_target))
        else $error("free velocity command not integrated");
    a_refuse_up: assert property (cmd_valid && status_bit12 && !upper_travel_limit && mode == `SLR_MODE_PP
        && $signed(cmd_target) > $signed(actual_pos) |=> $stable(actual_pos))
        else $error("command toward held limit moved the axis");
    a_warn_hold: assert property (stroke_warning |-> status_bit12)
        else $error("warning without a held direction");
    a_hold_cause: assert property ($rose(status_bit12) |-> !upper_travel_limit || !lower_travel_limit)
        else $error("hold raised with both limits on");
    // main scenarios: overrun alarm, warning raised, command against a hold
    c_alarm: cover property ($rose(command_error_alarm));
    c_warn: cover property ($rose(stroke_warning));
    c_held_cmd: cover property (cmd_valid && status_bit12);
endmodule // slr_monitor

// *** tb/stroke_limit_stop_and_release_tb.sv ***
// self-checking bench: drive and controller ends joined by the link, monitor beside it
// assumes the hw/ files compile first and slr_params.svh is on the include path
`timescale 1ns/1ps
`include "slr_params.svh"
module stroke_limit_stop_and_release_tb;
    import slr_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [2:0] in_pin_i = 3'h7;
    logic [7:0] cfg = 8'h00;              // {fn swap, dir, pole act, pole en, src, scope, auto, warn}
    logic       home_done_i = 1'b0;
    logic       user_cmd_valid_i = 1'b0;
    slr_pos_t   user_cmd_target_i = '0;
    slr_mode_t  user_mode_i = `SLR_MODE_PP;
    logic       user_upper_sw_i = 1'b1;
    logic       user_lower_sw_i = 1'b1;
    logic       user_recover_i = 1'b0;
    slr_pos_t   user_away_step_i = 32'h00000014;
    logic       assess = 1'b0;
    logic       motor_stop_o, busy_o, dog_o, pend = 1'b0;
    int         n_mismatch = 0, cmp_count = 0, cyc = 0;
    slr_pos_t   exp_q[$];
    slr_pos_t   pos;
    slr_link_if link ();
    slr_drive slr_drive_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(link), .in_pin_i(in_pin_i),
        .input_pin_a_function_i(cfg[7] ? `SLR_FN_REV_END : `SLR_FN_FWD_END),
        .input_pin_b_function_i(cfg[7] ? `SLR_FN_FWD_END : `SLR_FN_REV_END),
        .input_pin_c_function_i(`SLR_FN_DOG), .stroke_warning_select_i(cfg[0]), .auto_on_select_i(cfg[1]),
        .limit_enable_scope_i(cfg[2]), .sensor_source_select_i(cfg[3]), .pole_detect_limit_enable_i(cfg[4]),
        .pole_detect_active_i(cfg[5]), .release_assess_select_i(assess), .travel_direction_select_i(cfg[6]),
        .home_done_i(home_done_i), .motor_stop_o(motor_stop_o), .dog_o(dog_o));
    slr_ctrl slr_ctrl_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(link),
        .user_cmd_valid_i(user_cmd_valid_i), .user_cmd_target_i(user_cmd_target_i), .user_mode_i(user_mode_i),
        .user_upper_sw_i(user_upper_sw_i), .user_lower_sw_i(user_lower_sw_i), .user_recover_i(user_recover_i),
        .user_away_step_i(user_away_step_i), .busy_o(busy_o));
    slr_monitor slr_monitor_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_valid(link.cmd_valid),
        .cmd_target(link.cmd_target), .mode(link.mode), .actual_pos(link.actual_pos),
        .status_bit12(link.status_bit12), .upper_travel_limit(link.upper_travel_limit),
        .lower_travel_limit(link.lower_travel_limit), .command_error_alarm(link.command_error_alarm),
        .stroke_warning(link.stroke_warning), .home_valid(link.home_valid));

    // 4 ns clock
    always #2 core_clk_i = ~core_clk_i;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // flags {busy, hold, alarm, home, stop, warn, upper, lower} under a mask
    task automatic chk_flags(input logic [7:0] e, input logic [7:0] m);
        logic [7:0] got;
        got = {busy_o, link.status_bit12, link.command_error_alarm, link.home_valid, motor_stop_o,
               link.stroke_warning, link.upper_travel_limit, link.lower_travel_limit};
        cmp_count++;
        if ((got & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch at %0t: flags %h expected %h mask %h", $time, got, e, m);
        end
    endtask

    task automatic chk_pos(input slr_pos_t got, input slr_pos_t e);
        cmp_count++;
        if (got !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: position %h expected %h", $time, got, e);
        end
    endtask

    // one command through the controller end; the expected position is noted first
    task automatic cmd(input slr_mode_t md, input slr_pos_t t, input slr_pos_t e);
        user_mode_i <= md;
        user_cmd_target_i <= t;
        user_cmd_valid_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_i);
        user_cmd_valid_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask

    // take one end off (bit0 drive pin, bit1 controller switch) under a config, check, restore
    task automatic lim_case(input logic [7:0] c, input logic [1:0] off, input logic [7:0] e, input logic [7:0] m);
        cfg <= c;
        @(posedge core_clk_i);
        in_pin_i[0] <= !off[0];
        user_upper_sw_i <= !off[1];
        repeat (3) @(posedge core_clk_i);
        #1 chk_flags(e, m);
        in_pin_i[0] <= 1'b1;
        user_upper_sw_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 chk_flags(8'h03, 8'h0F);
    endtask

    // a position answer lands one cycle after the link strobe; negedge avoids the update race
    always @(negedge core_clk_i) begin
        if (pend)
            chk_pos(link.actual_pos, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        pend = link.cmd_valid;
    end

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h0C43));
        repeat (8) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk_flags(8'h03, 8'hFF);
        chk_pos(slr_pos_t'(dog_o), 32'h00000001);
        home_done_i <= 1'b1;
        @(posedge core_clk_i);
        home_done_i <= 1'b0;
        @(posedge core_clk_i);
        #1 chk_flags(8'h13, 8'hFF);
        pos = 32'h00000064 + ($urandom % 1000);
        cmd(`SLR_MODE_PP, pos, pos);
        cmd(`SLR_MODE_PV, 32'h00000007, pos + 7);
        pos = pos + 7;
        lim_case(8'h00, 2'h1, 8'h4D, 8'h4F);
        lim_case(8'h01, 2'h1, 8'h49, 8'h4F);
        lim_case(8'h02, 2'h1, 8'h03, 8'h0F);
        lim_case(8'h04, 2'h1, 8'h03, 8'h0C);
        lim_case(8'h30, 2'h1, 8'h03, 8'h0C);
        lim_case(8'h20, 2'h1, 8'h0D, 8'h0F);
        lim_case(8'h40, 2'h1, 8'h0E, 8'h0F);
        lim_case(8'h80, 2'h1, 8'h0E, 8'h0F);
        lim_case(8'h08, 2'h1, 8'h03, 8'h0C);
        lim_case(8'h08, 2'h2, 8'h0D, 8'h0F);
        cfg <= 8'h00;
        // held upper end: upward refused, downward taken, plain release
        in_pin_i[0] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        cmd(`SLR_MODE_PP, pos + 50, pos);
        cmd(`SLR_MODE_PP, pos - 30, pos - 30);
        pos = pos - 30;
        in_pin_i[0] <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 chk_flags(8'h03, 8'h4F);
        // csp recovery with assessment: follow-up, wait for hold to drop, then move away
        assess <= 1'b1;
        cmd(`SLR_MODE_CSP, pos, pos);
        in_pin_i[0] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        exp_q.push_back(pos);
        exp_q.push_back(pos - 20);
        user_recover_i <= 1'b1;
        @(posedge core_clk_i);
        user_recover_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        #1 chk_flags(8'hCD, 8'hCF);
        in_pin_i[0] <= 1'b1;
        for (int i = 0; i < 50 && busy_o !== 1'b0; i++)
            @(posedge core_clk_i);
        repeat (3) @(posedge core_clk_i);
        #1 chk_flags(8'h13, 8'hFF);
        pos = pos - 20;
        // overrun of the latched end in csp
        in_pin_i[0] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        cmd(`SLR_MODE_CSP, pos + 32'h40000000, pos);
        chk_flags(8'h28, 8'h38);
        in_pin_i[0] <= 1'b1;
        rst_b_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk_flags(8'h03, 8'hFF);
        final_report();
    end
endmodule // stroke_limit_stop_and_release_tb
